/* File: hsds_desc_source.sv */
// Top of the hub descriptor tail and string descriptor source.
// Assumes all inputs come from logic on mclk.
`timescale 1ns/1ps
module hsds_desc_source
  import hsds_pkg::*;
(
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              reset_n,
  // Configuration load port
  input  wire logic              cfg_wr_en,
  input  wire logic [7:0]        cfg_addr,
  input  wire logic [7:0]        cfg_wr_data,
  output logic      [7:0]        cfg_rd_data,
  // Descriptor request
  input  wire logic              req_valid,
  input  wire hsds_req_type      req,
  input  wire hsds_hub_head_type hub_head,
  output logic                   req_ready,
  output logic                   req_stall,
  output logic                   req_done,
  // Descriptor byte stream
  input  wire logic              desc_ready,
  output logic                   desc_valid,
  output hsds_beat_type          desc_beat,
  // Status
  output logic                   self_powered
);

  // ********************************
  // Configuration registers
  // ********************************
  logic [7:0] config_byte_one_q;
  logic [7:0] hub_current_self_powered_q;
  logic [7:0] hub_current_bus_powered_reg_q;
  logic [7:0] nonremovable_port_mask_q;
  logic [7:0] language_id_high_q;
  logic [7:0] language_id_low_q;
  logic [7:0] manufacturer_string_length_q;
  logic [7:0] product_string_length_q;

  logic       power_source_select;
  logic       mfr_wr;
  logic       prd_wr;
  logic [7:0] mfr_wr_idx;
  logic [7:0] prd_wr_idx;

  assign power_source_select = config_byte_one_q[HSDS_PWR_SEL_BIT];
  assign mfr_wr_idx          = cfg_addr - HSDS_OFF_MANUFACTURER_STRING_STORE;
  assign prd_wr_idx          = cfg_addr - HSDS_OFF_PRD_STR;
  assign mfr_wr              = cfg_wr_en && (cfg_addr >= HSDS_OFF_MANUFACTURER_STRING_STORE) && (mfr_wr_idx < HSDS_STR_BYTES);
  assign prd_wr              = cfg_wr_en && (cfg_addr >= HSDS_OFF_PRD_STR) && (prd_wr_idx < HSDS_STR_BYTES);

  // Fields hold their defaults until the configuration load overwrites them
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      config_byte_one_q             <= HSDS_RST_CFG1;
      hub_current_self_powered_q    <= HSDS_RST_HC_SP;
      hub_current_bus_powered_reg_q <= HSDS_RST_HC_BP;
      nonremovable_port_mask_q      <= HSDS_RST_NR_MASK;
      language_id_high_q            <= HSDS_RST_LANG_H;
      language_id_low_q             <= HSDS_RST_LANG_L;
      manufacturer_string_length_q  <= HSDS_RST_STR_LEN;
      product_string_length_q       <= HSDS_RST_STR_LEN;
    end else if (cfg_wr_en) begin
      case (cfg_addr)
        HSDS_OFF_CFG1:    config_byte_one_q             <= cfg_wr_data;
        HSDS_OFF_HC_SP:   hub_current_self_powered_q    <= cfg_wr_data;
        HSDS_OFF_HC_BP:   hub_current_bus_powered_reg_q <= cfg_wr_data;
        HSDS_OFF_NR_MASK: nonremovable_port_mask_q      <= cfg_wr_data;
        HSDS_OFF_LANG_H:  language_id_high_q            <= cfg_wr_data;
        HSDS_OFF_LANG_L:  language_id_low_q             <= cfg_wr_data;
        HSDS_OFF_MFR_LEN: manufacturer_string_length_q  <= cfg_wr_data;
        HSDS_OFF_PRD_LEN: product_string_length_q       <= cfg_wr_data;
        default: begin
        end
      endcase
    end
  end

  // ********************************
  // String storage
  // ********************************
  logic [7:0] str_rd_idx;
  logic [7:0] mfr_byte;
  logic [7:0] prd_byte;
  logic [7:0] mfr_cfg_byte;
  logic [7:0] prd_cfg_byte;

  hsds_string_store u_mfr_store (
    .mclk      (mclk),
    .reset_n   (reset_n),
    .wr_en     (mfr_wr),
    .wr_idx    (mfr_wr_idx),
    .wr_data   (cfg_wr_data),
    .rd_a_idx  (str_rd_idx),
    .rd_a_data (mfr_byte),
    .rd_b_idx  (mfr_wr_idx),
    .rd_b_data (mfr_cfg_byte)
  );

  hsds_string_store u_prd_store (
    .mclk      (mclk),
    .reset_n   (reset_n),
    .wr_en     (prd_wr),
    .wr_idx    (prd_wr_idx),
    .wr_data   (cfg_wr_data),
    .rd_a_idx  (str_rd_idx),
    .rd_a_data (prd_byte),
    .rd_b_idx  (prd_wr_idx),
    .rd_b_data (prd_cfg_byte)
  );

  // ********************************
  // Configuration readback
  // ********************************
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_rd_data <= HSDS_RST_BYTE;
    end else begin
      case (cfg_addr)
        HSDS_OFF_CFG1:    cfg_rd_data <= config_byte_one_q;
        HSDS_OFF_HC_SP:   cfg_rd_data <= hub_current_self_powered_q;
        HSDS_OFF_HC_BP:   cfg_rd_data <= hub_current_bus_powered_reg_q;
        HSDS_OFF_NR_MASK: cfg_rd_data <= nonremovable_port_mask_q;
        HSDS_OFF_LANG_H:  cfg_rd_data <= language_id_high_q;
        HSDS_OFF_LANG_L:  cfg_rd_data <= language_id_low_q;
        HSDS_OFF_MFR_LEN: cfg_rd_data <= manufacturer_string_length_q;
        HSDS_OFF_PRD_LEN: cfg_rd_data <= product_string_length_q;
        default: begin
          if ((cfg_addr >= HSDS_OFF_MANUFACTURER_STRING_STORE) && (mfr_wr_idx < HSDS_STR_BYTES)) begin
            cfg_rd_data <= mfr_cfg_byte;
          end else if ((cfg_addr >= HSDS_OFF_PRD_STR) && (prd_wr_idx < HSDS_STR_BYTES)) begin
            cfg_rd_data <= prd_cfg_byte;
          end else begin
            cfg_rd_data <= HSDS_RST_BYTE;
          end
        end
      endcase
    end
  end

  // ********************************
  // Request decode
  // ********************************
  hsds_state_type state_q;
  hsds_state_type state_d;
  hsds_src_type   src_q;
  hsds_src_type   req_src;
  logic           req_known;
  logic [7:0]     mfr_len_eff;
  logic [7:0]     prd_len_eff;
  logic [7:0]     desc_total;
  logic [7:0]     send_count;
  logic [7:0]     count_q;
  logic [7:0]     idx_q;
  logic           take;
  logic           advance;

  // Oversized lengths are clamped so the reply never runs past the storage
  assign mfr_len_eff = (manufacturer_string_length_q > HSDS_STR_BYTES) ? HSDS_STR_BYTES
                                                                       : manufacturer_string_length_q;
  assign prd_len_eff = (product_string_length_q > HSDS_STR_BYTES) ? HSDS_STR_BYTES
                                                                  : product_string_length_q;

  always_comb begin
    req_known = 1'b1;
    req_src   = HSDS_SRC_HUB;
    if ((req.dtype == HSDS_DT_HUB) || (req.dtype == HSDS_DT_HUB_OLD)) begin
      req_src = HSDS_SRC_HUB;
    end else if (req.dtype == HSDS_DT_STRING) begin
      case (req.index)
        HSDS_STR_LANG: req_src = HSDS_SRC_LANG;
        HSDS_STR_MFR:  req_src = HSDS_SRC_MFR;
        HSDS_STR_PRD:  req_src = HSDS_SRC_PRD;
        default:       req_known = 1'b0;
      endcase
    end else begin
      req_known = 1'b0;
    end
  end

  always_comb begin
    case (req_src)
      HSDS_SRC_HUB:  desc_total = HSDS_HUB_LEN;
      HSDS_SRC_LANG: desc_total = HSDS_LANG_LEN;
      HSDS_SRC_MFR:  desc_total = mfr_len_eff + HSDS_STR_HDR;
      HSDS_SRC_PRD:  desc_total = prd_len_eff + HSDS_STR_HDR;
      default:       desc_total = HSDS_HUB_LEN;
    endcase
  end

  // Truncate to the requested length
  assign send_count = (req.length < {8'h00, desc_total}) ? req.length[7:0] : desc_total;

  assign take    = (state_q == HSDS_IDLE) && req_valid && req_known;
  assign advance = (state_q == HSDS_SEND) && desc_valid && desc_ready;

  // ********************************
  // Byte selection for the next beat
  // ********************************
  hsds_src_type sel_src;
  logic [7:0]   sel_idx;
  logic [7:0]   sel_byte;
  logic [7:0]   hub_byte;
  logic [7:0]   hub_current;

  assign sel_src    = take ? req_src : src_q;
  assign sel_idx    = take ? 8'h00 : idx_q + 8'h01;
  assign str_rd_idx = sel_idx - HSDS_STR_HDR;

  // Report must follow the live operating mode
  assign hub_current = power_source_select ? hub_current_self_powered_q
                                           : hub_current_bus_powered_reg_q;

  hsds_hub_tail u_hub_tail (
    .hub_head               (hub_head),
    .hub_current            (hub_current),
    .nonremovable_port_mask (nonremovable_port_mask_q),
    .byte_idx               (sel_idx),
    .byte_data              (hub_byte)
  );

  always_comb begin
    sel_byte = HSDS_RST_BYTE;
    case (sel_src)
      HSDS_SRC_HUB: sel_byte = hub_byte;
      HSDS_SRC_LANG: begin
        case (sel_idx)
          8'h00:   sel_byte = HSDS_LANG_LEN;
          8'h01:   sel_byte = HSDS_DT_STRING;
          8'h02:   sel_byte = language_id_low_q;
          8'h03:   sel_byte = language_id_high_q;
          default: sel_byte = HSDS_RST_BYTE;
        endcase
      end
      HSDS_SRC_MFR: begin
        case (sel_idx)
          8'h00:   sel_byte = mfr_len_eff + HSDS_STR_HDR;
          8'h01:   sel_byte = HSDS_DT_STRING;
          default: sel_byte = mfr_byte;
        endcase
      end
      HSDS_SRC_PRD: begin
        case (sel_idx)
          8'h00:   sel_byte = prd_len_eff + HSDS_STR_HDR;
          8'h01:   sel_byte = HSDS_DT_STRING;
          default: sel_byte = prd_byte;
        endcase
      end
      default: sel_byte = HSDS_RST_BYTE;
    endcase
  end

  // ********************************
  // Transfer sequencer
  // ********************************
  always_comb begin
    case (state_q)
      HSDS_IDLE: begin
        if (take) begin
          state_d = (send_count == 8'h00) ? HSDS_FINISH : HSDS_SEND;
        end else begin
          state_d = HSDS_IDLE;
        end
      end
      HSDS_SEND:   state_d = (advance && desc_beat.last) ? HSDS_FINISH : HSDS_SEND;
      HSDS_FINISH: state_d = HSDS_IDLE;
      default:     state_d = HSDS_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_q   <= HSDS_IDLE;
      req_ready <= 1'b1;
    end else begin
      state_q   <= state_d;
      req_ready <= (state_d == HSDS_IDLE);
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      src_q   <= HSDS_SRC_HUB;
      count_q <= 8'h00;
      idx_q   <= 8'h00;
    end else if (take) begin
      src_q   <= req_src;
      count_q <= send_count;
      idx_q   <= 8'h00;
    end else if (advance) begin
      idx_q   <= sel_idx;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      desc_valid <= 1'b0;
      desc_beat  <= '0;
    end else if (take && (send_count != 8'h00)) begin
      desc_valid     <= 1'b1;
      desc_beat.data <= sel_byte;
      desc_beat.last <= (send_count == 8'h01);
    end else if (advance) begin
      desc_valid     <= !desc_beat.last;
      desc_beat.data <= desc_beat.last ? HSDS_RST_BYTE : sel_byte;
      desc_beat.last <= (sel_idx + 8'h01 == count_q);
    end
  end

  // Unknown types and string indices are refused; the control pipe stalls them
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      req_stall <= 1'b0;
      req_done  <= 1'b0;
    end else begin
      req_stall <= (state_q == HSDS_IDLE) && req_valid && !req_known;
      req_done  <= (state_q == HSDS_FINISH);
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      self_powered <= 1'b0;
    end else begin
      self_powered <= power_source_select;
    end
  end

endmodule // hsds_desc_source

/* File: hsds_pkg.sv */
// Shared constants and carrier types for the hub descriptor and string source.
// Assumes one clock domain; every user of this package runs on mclk.
package hsds_pkg;

  // ********************************
  // Configuration register offsets
  // ********************************
  localparam logic [7:0] HSDS_OFF_CFG1    = 8'h06;
  localparam logic [7:0] HSDS_OFF_NR_MASK = 8'h09;
  localparam logic [7:0] HSDS_OFF_HC_SP   = 8'h0E;
  localparam logic [7:0] HSDS_OFF_HC_BP   = 8'h0F;
  localparam logic [7:0] HSDS_OFF_LANG_H  = 8'h11;
  localparam logic [7:0] HSDS_OFF_LANG_L  = 8'h12;
  localparam logic [7:0] HSDS_OFF_MFR_LEN = 8'h13;
  localparam logic [7:0] HSDS_OFF_PRD_LEN = 8'h14;
  localparam logic [7:0] HSDS_OFF_MANUFACTURER_STRING_STORE = 8'h20;
  localparam logic [7:0] HSDS_OFF_PRD_STR = 8'h60;

  // Field position of the power source select bit inside config_byte_one
  localparam int         HSDS_PWR_SEL_BIT = 7;

  // Thirty characters of two bytes each
  localparam logic [7:0] HSDS_STR_BYTES   = 8'h3C;
  localparam int         HSDS_STR_DEPTH   = 60;

  // ********************************
  // Values after reset
  // ********************************
  localparam logic [7:0] HSDS_RST_CFG1    = 8'h00;
  localparam logic [7:0] HSDS_RST_NR_MASK = 8'h00;
  localparam logic [7:0] HSDS_RST_HC_SP   = 8'h01;
  localparam logic [7:0] HSDS_RST_HC_BP   = 8'h01;
  localparam logic [7:0] HSDS_RST_LANG_H  = 8'h04;
  localparam logic [7:0] HSDS_RST_LANG_L  = 8'h09;
  localparam logic [7:0] HSDS_RST_STR_LEN = 8'h00;
  localparam logic [7:0] HSDS_RST_BYTE    = 8'h00;

  // ********************************
  // Descriptor encodings
  // ********************************
  localparam logic [7:0] HSDS_DT_HUB      = 8'h29;
  localparam logic [7:0] HSDS_DT_HUB_OLD  = 8'h00;
  localparam logic [7:0] HSDS_DT_STRING   = 8'h03;
  localparam logic [7:0] HSDS_HUB_LEN     = 8'h09;
  localparam logic [7:0] HSDS_LANG_LEN    = 8'h04;
  localparam logic [7:0] HSDS_STR_HDR     = 8'h02;
  localparam logic [7:0] HSDS_PPCM_VALUE  = 8'hFF;
  localparam logic [7:0] HSDS_IDX_HC      = 8'h06;
  localparam logic [7:0] HSDS_IDX_REMOV   = 8'h07;
  localparam logic [7:0] HSDS_IDX_PPCM    = 8'h08;
  localparam logic [7:0] HSDS_STR_LANG    = 8'h00;
  localparam logic [7:0] HSDS_STR_MFR     = 8'h01;
  localparam logic [7:0] HSDS_STR_PRD     = 8'h02;

  // ********************************
  // Types
  // ********************************
  typedef struct packed {
    logic [7:0]  dtype;
    logic [7:0]  index;
    logic [15:0] length;
  } hsds_req_type;

  typedef struct packed {
    logic [7:0] data;
    logic       last;
  } hsds_beat_type;

  typedef logic [5:0][7:0] hsds_hub_head_type;

  typedef enum logic [1:0] {
    HSDS_IDLE   = 2'b00,
    HSDS_SEND   = 2'b01,
    HSDS_FINISH = 2'b11
  } hsds_state_type;

  typedef enum logic [1:0] {
    HSDS_SRC_HUB  = 2'b00,
    HSDS_SRC_LANG = 2'b01,
    HSDS_SRC_MFR  = 2'b10,
    HSDS_SRC_PRD  = 2'b11
  } hsds_src_type;

endpackage

/* File: hsds_string_store.sv */
// Flip-flop storage for one string of up to thirty characters.
// Assumes write and read indices come from logic on mclk.
`timescale 1ns/1ps
module hsds_string_store
  import hsds_pkg::*;
(
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       reset_n,
  // Write port
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_idx,
  input  wire logic [7:0] wr_data,
  // Read ports
  input  wire logic [7:0] rd_a_idx,
  output logic      [7:0] rd_a_data,
  input  wire logic [7:0] rd_b_idx,
  output logic      [7:0] rd_b_data
);

  logic [HSDS_STR_DEPTH-1:0][7:0] mem_q;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      mem_q <= '0;
    end else if (wr_en && (wr_idx < HSDS_STR_BYTES)) begin
      mem_q[wr_idx[5:0]] <= wr_data;
    end
  end

  // Out-of-range reads return zero instead of aliasing
  assign rd_a_data = (rd_a_idx < HSDS_STR_BYTES) ? mem_q[rd_a_idx[5:0]] : HSDS_RST_BYTE;
  assign rd_b_data = (rd_b_idx < HSDS_STR_BYTES) ? mem_q[rd_b_idx[5:0]] : HSDS_RST_BYTE;

endmodule // hsds_string_store

/* File: hsds_hub_tail.sv */
// Byte selector for the class-specific hub descriptor.
// Assumes the leading six bytes are supplied by the neighbouring hub logic.
`timescale 1ns/1ps
module hsds_hub_tail
  import hsds_pkg::*;
(
  // Descriptor sources
  input  wire hsds_hub_head_type hub_head,
  input  wire logic [7:0]        hub_current,
  input  wire logic [7:0]        nonremovable_port_mask,
  // Selection
  input  wire logic [7:0]        byte_idx,
  output logic      [7:0]        byte_data
);

  always_comb begin
    case (byte_idx)
      HSDS_IDX_HC:    byte_data = hub_current;
      HSDS_IDX_REMOV: byte_data = nonremovable_port_mask;
      HSDS_IDX_PPCM:  byte_data = HSDS_PPCM_VALUE;
      default: begin
        byte_data = (byte_idx < HSDS_IDX_HC) ? hub_head[byte_idx[2:0]] : HSDS_RST_BYTE;
      end
    endcase
  end

endmodule // hsds_hub_tail

/* File: hsds_desc_source_sva.sv */
// Port assertions for the descriptor source, bound to it.
// Assumes one mclk domain; configuration only via the load port.
`timescale 1ns/1ps
module hsds_desc_source_sva
  import hsds_pkg::*;
(
  // Clock, reset and configuration
  input wire logic              mclk,
  input wire logic              reset_n,
  input wire logic              cfg_wr_en,
  input wire logic [7:0]        cfg_addr,
  input wire logic [7:0]        cfg_wr_data,
  input wire logic [7:0]        cfg_rd_data,
  // Request and stream
  input wire logic              req_valid,
  input wire hsds_req_type      req,
  input wire hsds_hub_head_type hub_head,
  input wire logic              req_ready,
  input wire logic              req_stall,
  input wire logic              req_done,
  input wire logic              desc_ready,
  input wire logic              desc_valid,
  input wire hsds_beat_type     desc_beat,
  input wire logic              self_powered
);
  // ********************************
  // Helper state
  // ********************************
  logic [7:0]  dtype_q;
  logic [7:0]  index_q;
  logic [15:0] len_q;
  logic [15:0] cnt_q;
  logic [7:0]  sp_q;
  logic [7:0]  bp_q;
  logic [7:0]  nrm_q;
  logic        take;
  logic        is_hub;
  assign take   = req_valid && req_ready;
  assign is_hub = dtype_q == HSDS_DT_HUB || dtype_q == HSDS_DT_HUB_OLD;

  // Beats accepted since the last take
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      dtype_q <= 8'h00;
      index_q <= 8'h00;
      len_q   <= 16'h0000;
      cnt_q   <= 16'h0000;
    end else if (take) begin
      dtype_q <= req.dtype;
      index_q <= req.index;
      len_q   <= req.length;
      cnt_q   <= 16'h0000;
    end else if (desc_valid && desc_ready) begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end

  // Copies of the hub tail fields
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      sp_q  <= HSDS_RST_HC_SP;
      bp_q  <= HSDS_RST_HC_BP;
      nrm_q <= HSDS_RST_NR_MASK;
    end else if (cfg_wr_en) begin
      if (cfg_addr == HSDS_OFF_HC_SP) sp_q <= cfg_wr_data;
      if (cfg_addr == HSDS_OFF_HC_BP) bp_q <= cfg_wr_data;
      if (cfg_addr == HSDS_OFF_NR_MASK) nrm_q <= cfg_wr_data;
    end
  end

  // ********************************
  // Assertions
  // ********************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  hub_current_a: assert property (
    desc_valid && is_hub && cnt_q == 16'h0006 |-> desc_beat.data == (self_powered ? sp_q : bp_q))
    else $error("hub current byte wrong");
  port_mask_a: assert property (
    desc_valid && is_hub && cnt_q == 16'h0007 |-> desc_beat.data == nrm_q) else $error("removable byte wrong");
  power_mask_a: assert property (
    desc_valid && is_hub && cnt_q == 16'h0008 |-> desc_beat.data == 8'hFF) else $error("power mask byte wrong");
  lang_len_a: assert property (
    desc_valid && dtype_q == 8'h03 && index_q == 8'h00 && cnt_q == 16'h0000 |-> desc_beat.data == 8'h04)
    else $error("language length byte wrong");
  str_type_a: assert property (
    desc_valid && dtype_q == 8'h03 && cnt_q == 16'h0001 |-> desc_beat.data == 8'h03)
    else $error("string type byte wrong");
  legacy_hub_a: assert property (
    take && (req.dtype == 8'h29 || req.dtype == 8'h00) && req.length != 16'h0000
    |=> desc_valid && !req_stall && desc_beat.data == hub_head[0]) else $error("hub request not answered");
  bad_type_a: assert property (
    take && req.dtype == 8'h05 |=> req_stall && !desc_valid) else $error("unsupported type not refused");
  len_bound_a: assert property (
    desc_valid |-> cnt_q < len_q) else $error("beat beyond requested length");
  hub_last_a: assert property (
    desc_valid && desc_beat.last && is_hub |-> cnt_q == (len_q < 16'h0009 ? len_q - 16'h0001 : 16'h0008))
    else $error("hub last flag misplaced");
  zero_done_a: assert property (
    take && req.dtype == 8'h29 && req.length == 16'h0000 |-> ##[1:3] req_done) else $error("empty reply not done");
  beat_hold_a: assert property (
    desc_valid && !desc_ready |=> desc_valid && $stable(desc_beat)) else $error("beat dropped while waiting");

  cover property (take && req.dtype == 8'h00);
  cover property (desc_valid && !desc_ready);
  cover property (req_stall);
endmodule // hsds_desc_source_sva

bind hsds_desc_source hsds_desc_source_sva hsds_desc_source_sva_i (.mclk, .reset_n, .cfg_wr_en, .cfg_addr,
  .cfg_wr_data, .cfg_rd_data, .req_valid, .req, .hub_head, .req_ready, .req_stall, .req_done, .desc_ready,
  .desc_valid, .desc_beat, .self_powered);

/* File: hsds_host_model.sv */
// Behavioural upstream host: requests descriptors, collects bytes.
// Assumes fetch is called once at a time, 1 ns after an edge.
`timescale 1ns/1ps
module hsds_host_model
  import hsds_pkg::*;
(
  // Clock and reset
  input  wire logic          mclk,
  input  wire logic          reset_n,
  // Request side
  input  wire logic          req_ready,
  input  wire logic          req_stall,
  input  wire logic          req_done,
  output logic               req_valid,
  output hsds_req_type       req,
  // Stream side
  input  wire logic          desc_valid,
  input  wire hsds_beat_type desc_beat,
  output logic               desc_ready
);
  hsds_beat_type got[$];
  bit            slow = 1'b0;

  initial begin
    req_valid  = 1'b0;
    req        = '0;
    desc_ready = 1'b1;
  end

  // A slow host drops ready at random to exercise back-pressure
  always @(posedge mclk) desc_ready <= #1 (slow ? 1'($urandom) : 1'b1);

  always @(posedge mclk) begin
    if (desc_valid === 1'b1 && desc_ready === 1'b1) begin
      got.push_back(desc_beat);
    end
  end

  // One control read; fields scrambled once taken
  task automatic fetch(input hsds_req_type r, output bit st);
    int n;
    got.delete();
    req_valid = 1'b1;
    req       = r;
    n = 0;
    while (req_ready !== 1'b1 && n < 50) begin
      @(posedge mclk);
      #1;
      n++;
    end
    @(posedge mclk);
    #1;
    req_valid = 1'b0;
    req       = ~r;
    n = 0;
    while (req_done !== 1'b1 && req_stall !== 1'b1 && n < 400) begin
      @(posedge mclk);
      #1;
      n++;
    end
    st = req_stall === 1'b1;
    // An idle edge keeps the next request from redriving valid in this step
    @(posedge mclk);
    #1;
  endtask
endmodule // hsds_host_model

/* File: tb_top.sv */
// Self-checking bench for the descriptor source.
// Assumes the host model and the bound checker.
`timescale 1ns/1ps
module tb_top;
  import hsds_pkg::*;
  logic              mclk = 1'b0;
  logic              reset_n, cfg_wr_en, req_valid, req_ready, req_stall, req_done, desc_ready, desc_valid, self_powered;
  logic [7:0]        cfg_addr, cfg_wr_data, cfg_rd_data;
  hsds_req_type      req;
  hsds_hub_head_type hub_head;
  hsds_beat_type     desc_beat;
  logic [7:0]        m[256];
  logic [7:0]        exp_q[$];
  int                err_total = 0;
  int                n_tests = 0;

  always #4 mclk = ~mclk;

  hsds_desc_source hsds_desc_source_i (.mclk, .reset_n, .cfg_wr_en, .cfg_addr, .cfg_wr_data, .cfg_rd_data,
    .req_valid, .req, .hub_head, .req_ready, .req_stall, .req_done, .desc_ready, .desc_valid, .desc_beat,
    .self_powered);
  hsds_host_model hsds_host_model_i (.mclk, .reset_n, .req_ready, .req_stall, .req_done, .req_valid, .req,
    .desc_valid, .desc_beat, .desc_ready);

  // ********************************
  // Reference model and helpers
  // ********************************
  function automatic bit mapped(input logic [7:0] a);
    return a inside {HSDS_OFF_CFG1, HSDS_OFF_NR_MASK, HSDS_OFF_HC_SP, HSDS_OFF_HC_BP, HSDS_OFF_LANG_H,
      HSDS_OFF_LANG_L, HSDS_OFF_MFR_LEN, HSDS_OFF_PRD_LEN, [8'h20:8'h5B], [8'h60:8'h9B]};
  endfunction

  function automatic void build(input hsds_req_type r);
    int l;
    exp_q.delete();
    if (r.dtype == 8'h29 || r.dtype == 8'h00) begin
      for (int k = 0; k < 6; k++) exp_q.push_back(hub_head[k]);
      exp_q.push_back(m[HSDS_OFF_CFG1][7] ? m[HSDS_OFF_HC_SP] : m[HSDS_OFF_HC_BP]);
      exp_q.push_back(m[HSDS_OFF_NR_MASK]);
      exp_q.push_back(8'hFF);
    end else if (r.index == 8'h00) begin
      exp_q = '{8'h04, 8'h03, m[HSDS_OFF_LANG_L], m[HSDS_OFF_LANG_H]};
    end else begin
      l = m[r.index == 8'h01 ? HSDS_OFF_MFR_LEN : HSDS_OFF_PRD_LEN];
      exp_q.push_back(8'(l + 2));
      exp_q.push_back(8'h03);
      for (int k = 0; k < l; k++) exp_q.push_back(m[8'((r.index == 8'h01 ? 8'h20 : 8'h60) + k)]);
    end
    while (exp_q.size() > r.length) void'(exp_q.pop_back());
  endfunction

  task automatic check(input logic [7:0] seen, want);
    n_tests++;
    if (seen !== want) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  // Strobe is left high; the next rcfg or run lowers it, so no step drives it twice
  task automatic wcfg(input logic [7:0] a, d);
    cfg_wr_en   = 1'b1;
    cfg_addr    = a;
    cfg_wr_data = d;
    @(posedge mclk);
    #1;
    if (mapped(a)) m[a] = d;
  endtask

  task automatic rcfg(input logic [7:0] a);
    cfg_wr_en = 1'b0;
    cfg_addr  = a;
    @(posedge mclk);
    #1;
    check(cfg_rd_data, mapped(a) ? m[a] : 8'h00);
  endtask

  task automatic run(input logic [7:0] dt, ix, input logic [15:0] ln, input bit bad);
    hsds_req_type r;
    bit           st;
    r = {dt, ix, ln};
    cfg_wr_en = 1'b0;
    build(r);
    hsds_host_model_i.fetch(r, st);
    check(8'(st), 8'(bad));
    if (!bad) begin
      check(8'(hsds_host_model_i.got.size()), 8'(exp_q.size()));
      foreach (exp_q[k]) begin
        check(hsds_host_model_i.got[k].data, exp_q[k]);
        check(8'(hsds_host_model_i.got[k].last), 8'(k == exp_q.size() - 1));
      end
    end
  endtask

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ********************************
  // Test sequence
  // ********************************
  initial begin
    logic [7:0] lens[3];
    void'($urandom(32'hfde3_c0d1));
    reset_n     = 1'b0;
    cfg_wr_en   = 1'b0;
    cfg_addr    = 8'h00;
    cfg_wr_data = 8'h00;
    hub_head    = 48'({$urandom, $urandom});
    foreach (m[a]) m[a] = 8'h00;
    m[HSDS_OFF_HC_SP]  = HSDS_RST_HC_SP;
    m[HSDS_OFF_HC_BP]  = HSDS_RST_HC_BP;
    m[HSDS_OFF_LANG_H] = HSDS_RST_LANG_H;
    m[HSDS_OFF_LANG_L] = HSDS_RST_LANG_L;
    repeat (12) @(posedge mclk);
    #1;
    reset_n = 1'b1;
    for (int a = 0; a < 256; a++) rcfg(8'(a));
    run(HSDS_DT_STRING, HSDS_STR_LANG, 16'h00FF, 1'b0);
    wcfg(8'hF0, 8'hA5);
    rcfg(8'hF0);
    for (int s = 0; s < 2; s++) begin
      wcfg(HSDS_OFF_HC_SP, 8'($urandom));
      wcfg(HSDS_OFF_HC_BP, 8'($urandom));
      wcfg(HSDS_OFF_NR_MASK, 8'($urandom));
      wcfg(HSDS_OFF_CFG1, {s[0], 7'($urandom)});
      rcfg(HSDS_OFF_CFG1);
      rcfg(HSDS_OFF_HC_BP);
      check(8'(self_powered), 8'(s));
      hsds_host_model_i.slow = s[0];
      run(HSDS_DT_HUB, 8'h00, 16'h0040, 1'b0);
      run(HSDS_DT_HUB_OLD, 8'h00, 16'h0009, 1'b0);
      run(HSDS_DT_HUB, 8'h00, 16'h0007, 1'b0);
    end
    run(HSDS_DT_HUB, 8'h00, 16'h0000, 1'b0);
    wcfg(HSDS_OFF_LANG_H, 8'($urandom));
    wcfg(HSDS_OFF_LANG_L, 8'($urandom));
    run(HSDS_DT_STRING, HSDS_STR_LANG, 16'h0004, 1'b0);
    for (int a = 0; a < 60; a++) begin
      wcfg(8'(8'h20 + a), 8'($urandom));
      wcfg(8'(8'h60 + a), 8'($urandom));
    end
    lens = '{8'h00, 8'h3C, 8'($urandom_range(59, 1))};
    foreach (lens[i]) begin
      wcfg(HSDS_OFF_MFR_LEN, lens[i]);
      wcfg(HSDS_OFF_PRD_LEN, 8'h3C - lens[i]);
      run(HSDS_DT_STRING, HSDS_STR_MFR, 16'h00FF, 1'b0);
      run(HSDS_DT_STRING, HSDS_STR_PRD, 16'h00FF, 1'b0);
      run(HSDS_DT_STRING, HSDS_STR_MFR, 16'h0005, 1'b0);
    end
    run(8'h05, 8'h00, 16'h0009, 1'b1);
    run(HSDS_DT_STRING, 8'h03, 16'h0009, 1'b1);
    end_of_test();
  end

  // Hang guard, roughly sixty-five times the expected run
  initial begin
    #500000;
    err_total++;
    end_of_test();
  end
endmodule // tb_top
